// ---- hw/swa_regs.svh ----
`ifndef SWA_REGS_SVH
`define SWA_REGS_SVH

// system clock rate in MHz (10 ns period)
`define SWA_CLK_MHZ 100
// slave resumes after the wire rises on initial activation, microseconds
`define SWA_INIT_RESUME_US 700
// slave resumes after the wire rises from the deactivated state, microseconds
`define SWA_SUBSEQ_RESUME_US 500
// slave starts its answer to a power-state frame, microseconds
`define SWA_RESPONSE_US 2000
// slave gives up waiting for the activated state, milliseconds
`define SWA_INHIBIT_MS 100
// width of the inhibit timer, fits 10 000 000 cycles
`define SWA_INHIBIT_W 24
// width of the response timer, fits 200 000 cycles
`define SWA_RESPONSE_W 18

`endif

// ---- hw/swa_pkg.sv ----
package swa_pkg;

  typedef enum logic [1:0] {
    FRM_SYNC,
    FRM_POWER,
    FRM_READY,
    FRM_OTHER
  } frame_kind_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RESUME,
    ST_SEND,
    ST_WAIT,
    ST_INHIBIT
  } act_state_t;

endpackage

// ---- hw/wire_sampler.sv ----
`timescale 1ns/1ps

// brings the voltage signal into the system clock domain and finds its rising edges
module wire_sampler (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // meta_r feeds sync_r only
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r & ~prev_r;

endmodule

// ---- hw/single_wire_activation.sv ----
// What the activation scheme requires of master and slave; this block is the slave
// R01: master keeps wire low without card supply
// R02: wire rising starts slave's interface
// R03: master raises wire 1000 us after supply
// R04: master deactivates via deactivated interface state
// R05: master drops wire before supply removal
// R06: slave resumes within 700/500 us
// R07: master deactivates wire when no resume
// R08: master activates link after resume
// R09: no activated state: drop current, ignore master
// R10: slave sends sync, then waits master frame
// R11: full power: master answers power frame, repeat 0
// R12: low power: master stops after first sync
// R13: bad or missing frame: master requests repeat
// R14: power frame: repeat bit 1 resend, 0 ready
// R15: corrupted frame from master gets no answer
// R16: answer power frame within 2000 us
// R17: master stops on sync-repeat or ready
// R18: master sends at most three repeat requests
// R19: master treats out-of-order frames as corrupted
// R20: failed activation: master deactivates the wire
// R21: initial sync frames carry capability field
// R22: master adds capability field when announced
// R23: subsequent activation omits capability field everywhere
// R24: master may stop on first sync subsequently
// R25: current signal valid only while voltage high
// R26: slave keeps last frame for exact resend
`timescale 1ns/1ps
`include "swa_regs.svh"

module single_wire_activation #(
  parameter int unsigned INIT_RESUME_CYC = `SWA_INIT_RESUME_US * `SWA_CLK_MHZ,
  parameter int unsigned SUBSEQ_RESUME_CYC = `SWA_SUBSEQ_RESUME_US * `SWA_CLK_MHZ,
  parameter int unsigned RESPONSE_CYC = `SWA_RESPONSE_US * `SWA_CLK_MHZ,
  parameter int unsigned INHIBIT_CYC = `SWA_INHIBIT_MS * 1000 * `SWA_CLK_MHZ
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic voltage_signal_i,
  output logic current_signal_o,
  input wire logic supply_on_i,
  input wire logic link_activated_i,
  input wire logic link_deactivated_i,
  input wire logic rx_frame_valid_i,
  input wire logic rx_frame_ok_i,
  input wire swa_pkg::frame_kind_t rx_frame_kind_i,
  input wire logic rx_repeat_request_bit_i,
  output logic tx_req_o,
  output swa_pkg::frame_kind_t tx_kind_o,
  output logic tx_capability_info_field_o,
  input wire logic tx_ack_i,
  output logic activation_layer_busy_o,
  output logic subsequent_o,
  output logic inhibited_o
);
  import swa_pkg::*;

  logic s1_level;
  logic s1_rise;
  act_state_t state_r;
  logic resume_r;
  logic subsequent_r;
  logic [`SWA_INHIBIT_W-1:0] inh_cnt_r;
  logic [`SWA_RESPONSE_W-1:0] resp_cnt_r;
  logic resp_run_r;
  frame_kind_t last_kind_r;
  logic last_cap_r;
  logic pm_good;

  wire_sampler u_wire_sampler (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .pin_i(voltage_signal_i),
    .level_o(s1_level),
    .rise_o(s1_rise)
  );

  // a correct power-state frame while waiting for the master
  assign pm_good = (state_r == ST_WAIT) && rx_frame_valid_i && rx_frame_ok_i // [R15]
                   && (rx_frame_kind_i == FRM_POWER);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ST_OFF;
    end else if (!supply_on_i) begin
      state_r <= ST_OFF;
    end else begin
      unique case (state_r)
        ST_OFF: begin
          if (s1_rise) begin
            state_r <= ST_RESUME;
          end
        end
        ST_RESUME: begin
          if (link_activated_i) begin
            state_r <= ST_SEND; // [R10]
          end else if (link_deactivated_i) begin
            state_r <= ST_OFF;
          end else if (inh_cnt_r >= INHIBIT_CYC[`SWA_INHIBIT_W-1:0] - 1'b1) begin
            state_r <= ST_INHIBIT; // [R09]
          end
        end
        ST_SEND: begin
          if (link_deactivated_i) begin
            state_r <= ST_OFF;
          end else if (tx_ack_i) begin
            state_r <= ST_WAIT; // [R10]
          end
        end
        ST_WAIT: begin
          if (link_deactivated_i) begin
            state_r <= ST_OFF;
          end else if (pm_good) begin
            state_r <= ST_SEND; // [R14]
          end
        end
        // only card deactivation (supply off) leaves here
        ST_INHIBIT: begin
          state_r <= ST_INHIBIT; // [R09]
        end
      endcase
    end
  end

  // resume right on the rise: the window is met with margin, no timer needed
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resume_r <= 1'b0;
    end else if (!supply_on_i || link_deactivated_i) begin
      resume_r <= 1'b0;
    end else if (state_r == ST_OFF && s1_rise) begin
      resume_r <= 1'b1; // [R06]
    end else if (state_r == ST_RESUME && !link_activated_i
                 && inh_cnt_r >= INHIBIT_CYC[`SWA_INHIBIT_W-1:0] - 1'b1) begin
      resume_r <= 1'b0; // [R09]
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inh_cnt_r <= '0;
    end else if (state_r == ST_RESUME) begin
      inh_cnt_r <= inh_cnt_r + 1'b1; // [R09]
    end else begin
      inh_cnt_r <= '0;
    end
  end

  // after a deactivation in ST_WAIT, later rises are subsequent activations until supply drops
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      subsequent_r <= 1'b0;
    end else if (!supply_on_i) begin
      subsequent_r <= 1'b0;
    end else if (link_deactivated_i && state_r == ST_WAIT) begin
      subsequent_r <= 1'b1; // [R23]
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_req_o <= 1'b0;
      tx_kind_o <= FRM_SYNC;
      tx_capability_info_field_o <= 1'b0;
    end else if (!supply_on_i || link_deactivated_i) begin
      tx_req_o <= 1'b0;
    end else if (state_r == ST_RESUME && link_activated_i) begin
      tx_req_o <= 1'b1; // [R10]
      tx_kind_o <= FRM_SYNC;
      tx_capability_info_field_o <= ~subsequent_r; // [R21] [R23]
    end else if (pm_good && rx_repeat_request_bit_i) begin
      tx_req_o <= 1'b1; // [R14]
      tx_kind_o <= last_kind_r; // [R26]
      tx_capability_info_field_o <= last_cap_r;
    end else if (pm_good) begin
      tx_req_o <= 1'b1; // [R14]
      tx_kind_o <= FRM_READY;
      tx_capability_info_field_o <= 1'b0; // [R23]
    end else if (tx_ack_i) begin
      tx_req_o <= 1'b0;
    end
  end

  // copy of what actually left, for a bit-exact repeat
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_kind_r <= FRM_SYNC;
      last_cap_r <= 1'b0;
    end else if (tx_req_o && tx_ack_i) begin
      last_kind_r <= tx_kind_o; // [R26]
      last_cap_r <= tx_capability_info_field_o;
    end
  end

  // measures from the end of the power frame to the start of the answer
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_run_r <= 1'b0;
      resp_cnt_r <= '0;
    end else if (pm_good) begin
      resp_run_r <= 1'b1; // [R16]
      resp_cnt_r <= '0;
    end else if (tx_ack_i || link_deactivated_i || !supply_on_i) begin
      resp_run_r <= 1'b0;
    end else if (resp_run_r && resp_cnt_r != '1) begin
      resp_cnt_r <= resp_cnt_r + 1'b1;
    end
  end

  // current only means something while the master holds the wire high
  assign current_signal_o = resume_r & s1_level; // [R25]
  assign activation_layer_busy_o = (state_r != ST_OFF) && (state_r != ST_INHIBIT);
  assign subsequent_o = subsequent_r;
  assign inhibited_o = (state_r == ST_INHIBIT);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_resume_on_rise: assert property ( // [R06]
    (state_r == ST_OFF && s1_rise && supply_on_i && !link_deactivated_i) |=> resume_r ##1 (resume_r || !s1_level
      || link_deactivated_i || !supply_on_i || inhibited_o))
    else $error("no resume after the wire rose");
  a_resume_window: assert property ( // [R06]
    (state_r == ST_RESUME) |-> (resume_r || inh_cnt_r == '0))
    else $error("resume not driven inside the resume window");
  a_inhibit_bound: assert property ( // [R09]
    (state_r == ST_RESUME) |-> (inh_cnt_r < INHIBIT_CYC[`SWA_INHIBIT_W-1:0]))
    else $error("current held high past the inhibit timeout");
  a_inhibit_silent: assert property ( // [R09]
    inhibited_o |-> (!current_signal_o && !tx_req_o && $stable(tx_kind_o)))
    else $error("slave answers while inhibited");
  a_sync_first: assert property ( // [R10]
    (state_r == ST_RESUME && link_activated_i && supply_on_i && !link_deactivated_i)
      |=> (tx_req_o && tx_kind_o == FRM_SYNC && state_r == ST_SEND))
    else $error("first frame is not a sync frame");
  a_ready_answer: assert property ( // [R14]
    (pm_good && !rx_repeat_request_bit_i && supply_on_i && !link_deactivated_i)
      |=> (tx_req_o && tx_kind_o == FRM_READY))
    else $error("no ready frame for power frame with repeat 0");
  a_repeat_exact: assert property ( // [R26]
    (pm_good && rx_repeat_request_bit_i && supply_on_i && !link_deactivated_i)
      |=> (tx_req_o && tx_kind_o == $past(last_kind_r) && tx_capability_info_field_o == $past(last_cap_r)))
    else $error("repeat differs from the last frame sent");
  a_no_corrupt_reply: assert property ( // [R15]
    (state_r == ST_WAIT && !tx_req_o && rx_frame_valid_i && !rx_frame_ok_i) |=> !tx_req_o)
    else $error("answer to a corrupted frame");
  a_response_time: assert property ( // [R16]
    resp_run_r |-> (resp_cnt_r < RESPONSE_CYC[`SWA_RESPONSE_W-1:0]))
    else $error("answer to power frame started too late");
  a_cap_initial: assert property ( // [R21]
    (tx_req_o && tx_kind_o == FRM_SYNC && !subsequent_r) |-> tx_capability_info_field_o)
    else $error("initial sync frame without capability field");
  a_cap_subseq: assert property ( // [R23]
    (tx_req_o && subsequent_r) |-> !tx_capability_info_field_o)
    else $error("capability field in subsequent activation");
  a_current_gate: assert property ( // [R25]
    !s1_level |-> !current_signal_o)
    else $error("current driven while voltage signal low");

  c_initial_sync: cover property (tx_req_o && tx_ack_i && tx_kind_o == FRM_SYNC && !subsequent_r);
  c_ready_sent: cover property (tx_req_o && tx_ack_i && tx_kind_o == FRM_READY);
  c_repeat_sync: cover property (pm_good && rx_repeat_request_bit_i ##1 tx_kind_o == FRM_SYNC);
  c_inhibit: cover property (state_r == ST_RESUME ##1 state_r == ST_INHIBIT);
  c_subsequent: cover property (subsequent_r && tx_req_o && tx_kind_o == FRM_SYNC);

endmodule

// ---- sim/swa_master.sv ----
`timescale 1ns/1ps

module swa_master #(
  parameter int RAISE_CYC = 20
) (
  input wire logic clk_sys_i,
  input wire logic power_i,
  input wire logic wire_i,
  input wire logic slow_i,
  input wire logic tx_req_i,
  output logic supply_o,
  output logic voltage_o,
  output logic tx_ack_o
);
  int on_cnt = 0;
  int req_cnt = 0;
  initial tx_ack_o = 1'h0;
  assign supply_o = power_i;
  // wire falls with the supply at the latest, never rises before it settled
  assign voltage_o = power_i && wire_i && on_cnt >= RAISE_CYC;
  always @(posedge clk_sys_i) begin
    on_cnt <= power_i ? on_cnt + 1 : 0;
    // slow lower layer stretches the answer toward its deadline
    tx_ack_o <= tx_req_i && !tx_ack_o && req_cnt == (slow_i ? 40 : 2);
    req_cnt <= (tx_req_i && !tx_ack_o) ? req_cnt + 1 : 0;
  end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end

module testbench;
  import swa_pkg::*;
  logic clk_sys_i = 1'h0;
  logic nrst_i = 1'h0;
  logic power = 1'h0, wire_up = 1'h0, slow = 1'h0, act = 1'h0, deact = 1'h0;
  logic rv = 1'h0, rok = 1'h0, rrep = 1'h0;
  logic supply, volt, cur, ack, treq, tcap, busy, subs, inh;
  frame_kind_t rkind = FRM_OTHER;
  frame_kind_t tkind;
  int fail_count = 0;
  int num_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;

  swa_master master_u (.clk_sys_i(clk_sys_i), .power_i(power), .wire_i(wire_up), .slow_i(slow),
    .tx_req_i(treq), .supply_o(supply), .voltage_o(volt), .tx_ack_o(ack));
  single_wire_activation #(.RESPONSE_CYC(200), .INHIBIT_CYC(300)) dut_u (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .voltage_signal_i(volt), .current_signal_o(cur), .supply_on_i(supply),
    .link_activated_i(act), .link_deactivated_i(deact), .rx_frame_valid_i(rv), .rx_frame_ok_i(rok),
    .rx_frame_kind_i(rkind), .rx_repeat_request_bit_i(rrep), .tx_req_o(treq), .tx_kind_o(tkind),
    .tx_capability_info_field_o(tcap), .tx_ack_i(ack), .activation_layer_busy_o(busy),
    .subsequent_o(subs), .inhibited_o(inh));

  task automatic frame(frame_kind_t k, logic ok, logic rep);
    @(negedge clk_sys_i);
    rv = 1'h1;
    rok = ok;
    rkind = k;
    rrep = rep;
    @(negedge clk_sys_i);
    rv = 1'h0;
  endtask

  task automatic expect_tx(frame_kind_t k, logic cap);
    int n;
    n = 0;
    while (treq !== 1'h1 && n < 300) begin
      @(negedge clk_sys_i);
      n++;
    end
    `CHK("tx_req", 1'h1, treq)
    `CHK("tx_kind", k, tkind)
    `CHK("tx_cap", cap, tcap)
    while (ack !== 1'h1 && n < 300) begin
      @(negedge clk_sys_i);
      n++;
    end
    `CHK("answer_in_time", 1'h1, n < 200)
    @(negedge clk_sys_i);
    `CHK("tx_req_drop", 1'h0, treq)
  endtask

  task automatic expect_quiet();
    logic seen;
    seen = 1'h0;
    repeat (30) begin
      @(negedge clk_sys_i);
      seen = seen | treq;
    end
    `CHK("no_answer", 1'h0, seen)
  endtask

  task automatic wire_rise();
    int n;
    n = 0;
    @(negedge clk_sys_i);
    wire_up = 1'h1;
    while (cur !== 1'h1 && n < 100) begin
      @(negedge clk_sys_i);
      n++;
    end
    `CHK("resume", 1'h1, cur)
    `CHK("busy", 1'h1, busy)
    if (cur !== 1'h1) begin
      wire_up = 1'h0;
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_sys_i);
    s = 1'h1;
    @(negedge clk_sys_i);
    s = 1'h0;
  endtask

  task automatic t_initial();
    power = 1'h1;
    repeat (30) @(negedge clk_sys_i);
    wire_rise();
    `CHK("subsequent", 1'h0, subs)
    pulse(act);
    expect_tx(FRM_SYNC, 1'h1);
    frame(FRM_POWER, 1'h1, 1'h1);
    expect_tx(FRM_SYNC, 1'h1);
    frame(FRM_POWER, 1'h0, 1'h0);
    expect_quiet();
    frame(FRM_READY, 1'h1, 1'h0);
    expect_quiet();
    slow = 1'h1;
    frame(FRM_POWER, 1'h1, 1'h0);
    expect_tx(FRM_READY, 1'h0);
    frame(FRM_POWER, 1'h1, 1'h1);
    expect_tx(FRM_READY, 1'h0);
    slow = 1'h0;
  endtask

  task automatic t_subsequent();
    pulse(deact);
    wire_up = 1'h0;
    repeat (4) @(negedge clk_sys_i);
    `CHK("current_low", 1'h0, cur)
    `CHK("subsequent", 1'h1, subs)
    wire_rise();
    pulse(act);
    expect_tx(FRM_SYNC, 1'h0);
    frame(FRM_POWER, 1'h1, 1'h1);
    expect_tx(FRM_SYNC, 1'h0);
    expect_quiet();
  endtask

  task automatic t_low_power();
    pulse(deact);
    wire_up = 1'h0;
    repeat (4) @(negedge clk_sys_i);
    wire_rise();
    pulse(act);
    expect_tx(FRM_SYNC, 1'h0);
    expect_quiet();
    `CHK("waits_for_master", 1'h1, busy)
  endtask

  task automatic t_inhibit();
    wire_up = 1'h0;
    power = 1'h0;
    repeat (4) @(negedge clk_sys_i);
    `CHK("subsequent", 1'h0, subs)
    power = 1'h1;
    repeat (30) @(negedge clk_sys_i);
    wire_rise();
    repeat (320) @(negedge clk_sys_i);
    `CHK("current_dropped", 1'h0, cur)
    `CHK("inhibited", 1'h1, inh)
    pulse(act);
    expect_quiet();
    wire_up = 1'h0;
    repeat (4) @(negedge clk_sys_i);
    `CHK("still_inhibited", 1'h1, inh)
    power = 1'h0;
    repeat (2) @(negedge clk_sys_i);
    `CHK("inhibit_left", 1'h0, inh)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk_sys_i);
    nrst_i = 1'h1;
    t_initial();
    t_subsequent();
    t_low_power();
    t_inhibit();
    tally_and_finish();
  end

  // whole run is under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule
